/* common/sor_pkg.sv */
// Purpose: constants for the security option register bank
// Assumes: byte-wide register port on the command data interface
// Notes:   offsets are the device register addresses
package sor_pkg;
  localparam logic [7:0] ADDR_PKT_OPT_NV  = 8'h83;
  localparam logic [7:0] ADDR_SEC_OPT_NV  = 8'h84;
  localparam logic [7:0] ADDR_LAST_ADDR3  = 8'h8C;
  localparam logic [7:0] ADDR_LAST_ADDR2  = 8'h8D;
  localparam logic [7:0] ADDR_LAST_ADDR1  = 8'h8E;
  localparam logic [7:0] ADDR_LAST_ADDR0  = 8'h8F;
  localparam logic [7:0] ADDR_PKT_OPT_VOL = 8'hD3;
  localparam logic [7:0] ADDR_SEC_OPT_VOL = 8'hD4;

  localparam int BIT_RESTORE_PERMIT = 0;
  localparam int BIT_KEY_SHARE      = 1;
  localparam int BIT_KEY_CHANGE     = 2;
  localparam int BIT_ADDR_CHANGE    = 3;
  localparam int BIT_NODE_ROLE      = 4;
  localparam int BIT_ACCEPT_PLAIN   = 5;
  localparam int BIT_RESERVED       = 6;
  localparam int BIT_CHANGE_ENABLE  = 7;

  localparam logic [7:0]  RST_PKT_OPT   = 8'h00;
  localparam logic [7:0]  RST_SEC_OPT   = 8'hFF;
  localparam logic [31:0] RST_LAST_ADDR = 32'h0000_0000;

  localparam int    CLK_HZ          = 125_000_000;
  localparam int    SHORT_PRESSES   = 4;
  localparam int    HOLD_SECONDS    = 3;
  localparam longint HOLD_CYCLES_L  = longint'(HOLD_SECONDS) * longint'(CLK_HZ);
  localparam logic [31:0] HOLD_CYCLES = HOLD_CYCLES_L[31:0];
  localparam logic [31:0] GAP_CYCLES  = 32'd125_000_000;
  localparam logic [31:0] DEBOUNCE_CYCLES = 32'd1_250_000;

  typedef enum logic [1:0] {
    SOR_BTN_IDLE  = 2'b00,
    SOR_BTN_PRESS = 2'b01,
    SOR_BTN_GAP   = 2'b11,
    SOR_BTN_HOLD  = 2'b10
  } sor_btn_e;
endpackage

/* common/sor_btn_if.sv */
`timescale 1ns/1ps
// Purpose: carrier between bank and button sequence detector
// Assumes: single clock
// Notes:   restore_req is a one-cycle pulse
interface sor_btn_if;
  logic permit;
  logic restore_req;
  modport bank (output permit, input restore_req);
  modport det  (input permit, output restore_req);
endinterface

/* rtl/sor_btn_seq.sv */
`timescale 1ns/1ps
// Purpose: detect four short presses followed by a long hold
// Assumes: button input already debounced and synchronous
// Notes:   a press longer than the short limit that is not the fifth restarts the count
module sor_btn_seq
  import sor_pkg::*;
#(
  parameter int          PRESSES = SHORT_PRESSES,
  parameter logic [31:0] HOLD    = HOLD_CYCLES,
  parameter logic [31:0] GAP     = GAP_CYCLES,
  parameter logic [31:0] SHORT   = DEBOUNCE_CYCLES * 32'd40
) (
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  input  wire logic pairing_button_input,
  sor_btn_if.det    bus
);
  sor_btn_e    state_ff;
  logic [31:0] cnt_ff;
  logic [2:0]  presses_ff;
  logic        btn_ff;
  logic        req_ff;

  assign bus.restore_req = req_ff;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      btn_ff <= 1'b0;
    end else begin
      btn_ff <= pairing_button_input;
    end
  end

  // RL7 press and hold
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_ff   <= SOR_BTN_IDLE;
      cnt_ff     <= 32'h0;
      presses_ff <= 3'h0;
      req_ff     <= 1'b0;
    end else begin
      req_ff <= 1'b0;
      cnt_ff <= cnt_ff + 32'h1;
      unique case (state_ff)
        SOR_BTN_IDLE: begin
          presses_ff <= 3'h0;
          cnt_ff     <= 32'h0;
          // rising edge only, so a held button cannot re-arm
          if (pairing_button_input && !btn_ff && bus.permit) begin
            state_ff <= SOR_BTN_PRESS;
          end
        end
        SOR_BTN_PRESS: begin
          if (presses_ff == 3'(PRESSES)) begin
            state_ff <= SOR_BTN_HOLD;
          end else if (!btn_ff) begin
            presses_ff <= presses_ff + 3'h1;
            cnt_ff     <= 32'h0;
            state_ff   <= SOR_BTN_GAP;
          end else if (cnt_ff >= SHORT) begin
            state_ff <= SOR_BTN_IDLE;
          end
        end
        SOR_BTN_GAP: begin
          if (btn_ff) begin
            cnt_ff   <= 32'h0;
            state_ff <= SOR_BTN_PRESS;
          end else if (cnt_ff >= GAP) begin
            state_ff <= SOR_BTN_IDLE;
          end
        end
        SOR_BTN_HOLD: begin
          if (!btn_ff || !bus.permit) begin
            state_ff <= SOR_BTN_IDLE;
          end else if (cnt_ff >= HOLD - 32'h1) begin
            // single pulse, then wait for release
            req_ff   <= 1'b1;
            cnt_ff   <= 32'h0;
            state_ff <= SOR_BTN_IDLE;
          end
        end
      endcase
    end
  end
endmodule

/* rtl/sor_regs.sv */
`timescale 1ns/1ps
// Purpose: security option, packet option and last-address registers
// Assumes: host port is a one-cycle byte write or read strobe; radio core drives events
// Notes:   non-volatile copies are modelled as flops reloaded by factory restore
//          a read in the restore cycle still returns the old byte
//          key generation beats a join, a join beats a host record write
//          each security copy is locked against its own current value
//
// Notes on behaviour
// (RL1) packet options stored, no effect here
// (RL2) admin join assigns next address, increments record
// (RL3) key generation loads admin's own address
// (RL4) security byte at D4/84, fixed bit layout
// (RL5) joins use stored copy; reception uses working
// (RL6) host writes reserved bit 6 as one
// (RL7) restore permitted: four presses, three-second hold
// (RL8) key share bit decides key sent
// (RL9) join key change gated; serial always allowed
// (RL10) address change bit gates join addressing
// (RL11) role bit: one node, zero admin
// (RL12) role one-to-zero needs both keys clear
// (RL13) button key generation clears role bit
// (RL14) plain packets dropped unless accept bit set
// (RL15) change-enable clear blocks three bit raises
// (RL16) blocked change answered with negative acknowledge
// (RL17) only factory restore lifts the lock; here sys_rst also reloads both security copies and lifts it
// (RL18) accepted plain packet sets exception flag
// (RL19) check against stored value before update
module sor_regs
  import sor_pkg::*;
#(
  parameter logic [31:0] HOLD = sor_pkg::HOLD_CYCLES
) (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  input  wire logic [7:0]  addr,
  input  wire logic [7:0]  wr_data,
  output logic             ack,
  output logic             nack,
  output logic [7:0]       rd_data,
  input  wire logic [31:0] own_address,
  input  wire logic        vol_key_clear,
  input  wire logic        nv_key_clear,
  input  wire logic        key_generated,
  input  wire logic        button_key_generate,
  input  wire logic        join_assign,
  input  wire logic        join_key_change_req,
  input  wire logic        serial_key_change_req,
  input  wire logic        rx_packet_valid,
  input  wire logic        rx_packet_plain,
  input  wire logic        flag_clear,
  input  wire logic        pairing_button_input,
  output logic             node_role,
  output logic             join_send_key,
  output logic             join_addr_change_ok,
  output logic             key_change_ok,
  output logic             rx_accept,
  output logic [31:0]      assigned_address,
  output logic             plain_packet_received_flag,
  output logic             factory_restore
);
  logic [7:0]  pkt_vol_ff;
  logic [7:0]  pkt_nv_ff;
  logic [7:0]  sec_vol_ff;
  logic [7:0]  sec_nv_ff;
  logic [31:0] last_addr_ff;
  logic [31:0] nxt_last_addr;
  logic        flag_ff;
  logic        ack_ff;
  logic        nack_ff;
  logic [7:0]  rd_ff;
  logic        addr_ok;
  logic        sec_blocked;
  logic        do_restore;
  logic [7:0]  nxt_sec_vol;
  logic [7:0]  nxt_sec_nv;
  logic        sec_vol_wr;
  logic        sec_nv_wr;
  logic [3:0]  rec_wr;

  sor_btn_if btn ();

  sor_btn_seq #(
    .HOLD (HOLD)
  ) u_btn (
    .ref_clk              (ref_clk),
    .sys_rst              (sys_rst),
    .pairing_button_input (pairing_button_input),
    .bus                  (btn.det)
  );

  function automatic logic sor_blocked(input logic [7:0] cur, input logic [7:0] nw,
                                       input logic keys_clear);
    logic lock;
    logic raise;
    logic role;
    lock  = 1'b0;
    raise = 1'b0;
    role  = 1'b0;
    // RL15 lock on raises
    raise = (!cur[BIT_KEY_SHARE] && nw[BIT_KEY_SHARE])
          || (!cur[BIT_CHANGE_ENABLE] && nw[BIT_CHANGE_ENABLE])
          || (!cur[BIT_ACCEPT_PLAIN] && nw[BIT_ACCEPT_PLAIN]);
    lock  = !cur[BIT_CHANGE_ENABLE] && raise;
    // RL12 role drop guard
    role  = cur[BIT_NODE_ROLE] && !nw[BIT_NODE_ROLE] && !keys_clear;
    return lock || role;
  endfunction

  // reserved bit kept high so a careless host cannot clear it
  function automatic logic [7:0] sor_sec_value(input logic [7:0] nw);
    return nw | (8'h01 << BIT_RESERVED);
  endfunction

  // unmapped offsets read as zero
  function automatic logic [7:0] sor_read_byte(input logic [7:0] a, input logic [7:0] pv,
                                               input logic [7:0] pn, input logic [7:0] sv,
                                               input logic [7:0] sn, input logic [31:0] rec);
    logic [7:0] q;
    q = 8'h00;
    unique case (a)
      ADDR_PKT_OPT_NV:  q = pn;
      ADDR_PKT_OPT_VOL: q = pv;
      ADDR_SEC_OPT_NV:  q = sn;
      ADDR_SEC_OPT_VOL: q = sv;
      ADDR_LAST_ADDR3:  q = rec[31:24];
      ADDR_LAST_ADDR2:  q = rec[23:16];
      ADDR_LAST_ADDR1:  q = rec[15:8];
      ADDR_LAST_ADDR0:  q = rec[7:0];
      default:          q = 8'h00;
    endcase
    return q;
  endfunction

  // unmapped offsets are refused on read and write alike
  function automatic logic sor_mapped(input logic [7:0] a);
    return (a == ADDR_PKT_OPT_NV) || (a == ADDR_SEC_OPT_NV)
        || (a == ADDR_PKT_OPT_VOL) || (a == ADDR_SEC_OPT_VOL)
        || (a >= ADDR_LAST_ADDR3 && a <= ADDR_LAST_ADDR0);
  endfunction

  // RL5 stored copy drives joins
  assign btn.permit          = sec_nv_ff[BIT_RESTORE_PERMIT];
  assign do_restore          = btn.restore_req;
  assign factory_restore     = do_restore;
  // RL11 role select
  assign node_role           = sec_nv_ff[BIT_NODE_ROLE];
  // RL8 key share
  assign join_send_key       = !sec_nv_ff[BIT_NODE_ROLE] && sec_nv_ff[BIT_KEY_SHARE];
  // RL10 address change gate
  assign join_addr_change_ok = sec_nv_ff[BIT_ADDR_CHANGE];
  // RL9 key change gate
  assign key_change_ok       = serial_key_change_req
                             || (join_key_change_req && sec_nv_ff[BIT_KEY_CHANGE]);
  // RL14 plain packet filter
  assign rx_accept           = rx_packet_valid
                             && (!rx_packet_plain || sec_vol_ff[BIT_ACCEPT_PLAIN]);
  assign assigned_address    = last_addr_ff;
  assign plain_packet_received_flag = flag_ff;
  assign ack                 = ack_ff;
  assign nack                = nack_ff;
  assign rd_data             = rd_ff;

  assign addr_ok = sor_mapped(addr);

  // RL19 compare with stored
  always_comb begin
    sec_blocked = 1'b0;
    if (addr == ADDR_SEC_OPT_NV) begin
      sec_blocked = sor_blocked(sec_nv_ff, wr_data, vol_key_clear && nv_key_clear);
    end else if (addr == ADDR_SEC_OPT_VOL) begin
      sec_blocked = sor_blocked(sec_vol_ff, wr_data, vol_key_clear && nv_key_clear);
    end
  end

  // accepted access
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= (rd_en && addr_ok) || (wr_en && addr_ok && !sec_blocked);
    end
  end

  // RL16 negative acknowledge
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      nack_ff <= 1'b0;
    end else begin
      nack_ff <= (rd_en || wr_en) && (!addr_ok || (wr_en && sec_blocked));
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rd_ff <= 8'h00;
    end else if (rd_en) begin
      rd_ff <= sor_read_byte(addr, pkt_vol_ff, pkt_nv_ff, sec_vol_ff, sec_nv_ff, last_addr_ff);
    end
  end

  // RL1 stored, otherwise unused
  always_ff @(posedge ref_clk) begin
    if (sys_rst || do_restore) begin
      pkt_vol_ff <= RST_PKT_OPT;
    end else if (wr_en && addr == ADDR_PKT_OPT_VOL) begin
      pkt_vol_ff <= wr_data;
    end
  end

  // stored packet options
  always_ff @(posedge ref_clk) begin
    if (sys_rst || do_restore) begin
      pkt_nv_ff <= RST_PKT_OPT;
    end else if (wr_en && addr == ADDR_PKT_OPT_NV) begin
      pkt_nv_ff <= wr_data;
    end
  end

  // RL4 security byte write strobes
  assign sec_vol_wr = wr_en && !sec_blocked && (addr == ADDR_SEC_OPT_VOL);
  assign sec_nv_wr  = wr_en && !sec_blocked && (addr == ADDR_SEC_OPT_NV);

  always_comb begin
    nxt_sec_vol = sec_vol_ff;
    nxt_sec_nv  = sec_nv_ff;
    if (sec_vol_wr) begin
      nxt_sec_vol = sor_sec_value(wr_data);
    end
    if (sec_nv_wr) begin
      nxt_sec_nv = sor_sec_value(wr_data);
    end
    // RL13 button key generation
    if (button_key_generate) begin
      nxt_sec_vol[BIT_NODE_ROLE] = 1'b0;
      nxt_sec_nv[BIT_NODE_ROLE]  = 1'b0;
    end
  end

  // RL17 restore lifts lock
  always_ff @(posedge ref_clk) begin
    if (sys_rst || do_restore) begin
      sec_vol_ff <= RST_SEC_OPT;
    end else begin
      sec_vol_ff <= nxt_sec_vol;
    end
  end

  // stored copy, the one that joins follow
  always_ff @(posedge ref_clk) begin
    if (sys_rst || do_restore) begin
      sec_nv_ff <= RST_SEC_OPT;
    end else begin
      sec_nv_ff <= nxt_sec_nv;
    end
  end

  // RL2 record byte strobes; lowest offset is the top byte
  for (genvar gi = 0; gi < 4; gi++) begin : g_rec
    assign rec_wr[gi] = wr_en && (addr == ADDR_LAST_ADDR0 - 8'(gi));
  end

  // RL2 next address assigned
  always_comb begin
    nxt_last_addr = last_addr_ff;
    for (int i = 0; i < 4; i++) begin
      if (rec_wr[i]) begin
        nxt_last_addr[i*8 +: 8] = wr_data;
      end
    end
    if (join_assign && !sec_nv_ff[BIT_NODE_ROLE]) begin
      nxt_last_addr = last_addr_ff + 32'h1;
    end
    // RL3 key generation reload
    if (key_generated) begin
      nxt_last_addr = own_address;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst || do_restore) begin
      last_addr_ff <= RST_LAST_ADDR;
    end else begin
      last_addr_ff <= nxt_last_addr;
    end
  end

  // RL18 plain packet flag, set wins over clear
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      flag_ff <= 1'b0;
    end else if (rx_accept && rx_packet_plain) begin
      flag_ff <= 1'b1;
    end else if (flag_clear) begin
      flag_ff <= 1'b0;
    end
  end
endmodule

/* dv/sor_regs_checker.sv */
// Purpose: port checks for the security option bank
// Assumes: one clock, sync active-high reset
// Notes:   bound to every sor_regs instance
`timescale 1ns/1ps
module sor_regs_checker (
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  input wire logic        wr_en,
  input wire logic        rd_en,
  input wire logic [7:0]  addr,
  input wire logic        ack,
  input wire logic        nack,
  input wire logic [31:0] own_address,
  input wire logic        key_generated,
  input wire logic        join_assign,
  input wire logic        serial_key_change_req,
  input wire logic        rx_packet_valid,
  input wire logic        rx_packet_plain,
  input wire logic        flag_clear,
  input wire logic        node_role,
  input wire logic        join_send_key,
  input wire logic        key_change_ok,
  input wire logic        rx_accept,
  input wire logic [31:0] assigned_address,
  input wire logic        plain_packet_received_flag
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  a_access_answer: assert property ((wr_en || rd_en) |=> (ack ^ nack))
    else $error("access not answered");
  a_unmapped_nack: assert property ((wr_en || rd_en) && !(addr inside {8'h83, 8'h84,
    [8'h8C:8'h8F], 8'hD3, 8'hD4}) |=> nack) else $error("unmapped access not refused");
  a_idle_quiet: assert property (!wr_en && !rd_en |=> !ack && !nack)
    else $error("answer without access");
  a_cipher_accept: assert property (rx_packet_valid && !rx_packet_plain |-> rx_accept)
    else $error("encrypted packet dropped");
  a_accept_valid: assert property (rx_accept |-> rx_packet_valid)
    else $error("accept without packet");
  a_flag_set: assert property (rx_accept && rx_packet_plain |=> plain_packet_received_flag)
    else $error("plain flag not set");
  a_flag_hold: assert property (!rx_accept && !flag_clear
    |=> $stable(plain_packet_received_flag)) else $error("plain flag moved");
  a_keygen_load: assert property (key_generated |=> assigned_address == $past(own_address))
    else $error("record not loaded");
  a_join_incr: assert property (join_assign && !key_generated && !node_role
    |=> assigned_address == $past(assigned_address) + 32'h1) else $error("record not advanced");
  a_serial_key: assert property (serial_key_change_req |-> key_change_ok)
    else $error("serial key change refused");
  a_node_no_key: assert property (node_role |-> !join_send_key)
    else $error("node sends key");
endmodule
bind sor_regs sor_regs_checker chk (.ref_clk, .sys_rst, .wr_en, .rd_en, .addr, .ack, .nack,
  .own_address, .key_generated, .join_assign, .serial_key_change_req, .rx_packet_valid,
  .rx_packet_plain, .flag_clear, .node_role, .join_send_key, .key_change_ok, .rx_accept,
  .assigned_address, .plain_packet_received_flag);

/* dv/sor_host.sv */
// Purpose: host controller model on the register port
// Assumes: called just after a falling clock edge
// Notes:   released address and data lines show inverted values; both strobes go low
`timescale 1ns/1ps
module sor_host (
  input  wire logic       ref_clk,
  output logic            wr_en,
  output logic            rd_en,
  output logic [7:0]      addr,
  output logic [7:0]      wr_data,
  input  wire logic       ack,
  input  wire logic       nack,
  input  wire logic [7:0] rd_data
);
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 8'h00;
    wr_data = 8'h00;
  end
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d,
                      output logic ok, output logic bad, output logic [7:0] q);
    wr_en = wr;
    rd_en = !wr;
    addr = a;
    // reserved bit one on the security bytes only
    wr_data = (a == 8'h84 || a == 8'hD4) ? (d | 8'h40) : d;
    @(negedge ref_clk);
    ok = ack;
    bad = nack;
    q = rd_data;
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = ~a;
    wr_data = ~wr_data;
    @(negedge ref_clk);
  endtask
endmodule

/* dv/tb_top.sv */
// Purpose: directed test of the security option bank
// Assumes: short hold count, button presses far below limits
// Notes:   inputs change at the falling edge
`timescale 1ns/1ps
module tb_top;
  logic ref_clk = 1'b0, sys_rst = 1'b1, pairing_button_input = 1'b0;
  logic wr_en, rd_en, ack, nack, node_role, join_send_key, join_addr_change_ok;
  logic key_change_ok, rx_accept, plain_packet_received_flag, factory_restore, ok, bad;
  logic [7:0] addr, wr_data, rd_data, q;
  logic [31:0] assigned_address, own_address = 32'h0;
  logic vol_key_clear = 1'b0, nv_key_clear = 1'b0, key_generated = 1'b0, button_key_generate = 1'b0;
  logic join_assign = 1'b0, join_key_change_req = 1'b0, serial_key_change_req = 1'b0;
  logic rx_packet_valid = 1'b0, rx_packet_plain = 1'b1, flag_clear = 1'b0;
  int err_count = 0;
  int cmp_count = 0;
  always #4 ref_clk = ~ref_clk;
  sor_regs #(.HOLD(32'd50)) dut (.ref_clk, .sys_rst, .wr_en, .rd_en, .addr, .wr_data, .ack,
    .nack, .rd_data, .own_address, .vol_key_clear, .nv_key_clear, .key_generated,
    .button_key_generate, .join_assign, .join_key_change_req, .serial_key_change_req,
    .rx_packet_valid, .rx_packet_plain, .flag_clear, .pairing_button_input, .node_role,
    .join_send_key, .join_addr_change_ok, .key_change_ok, .rx_accept, .assigned_address,
    .plain_packet_received_flag, .factory_restore);
  sor_host h (.ref_clk, .wr_en, .rd_en, .addr, .wr_data, .ack, .nack, .rd_data);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic exp_ok);
    h.xfer(1'b1, a, d, ok, bad, q);
    chk({30'h0, ok, bad}, {30'h0, exp_ok, !exp_ok});
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    h.xfer(1'b0, a, 8'h00, ok, bad, q);
    chk({23'h0, ok, q}, {23'h0, 1'b1, exp});
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge ref_clk);
    s = 1'b0;
  endtask
  task automatic rx(input logic pl, input logic acc, input logic flg);
    rx_packet_plain = pl;
    rx_packet_valid = 1'b1;
    #1 chk(rx_accept, acc);
    @(negedge ref_clk);
    rx_packet_valid = 1'b0;
    chk(plain_packet_received_flag, flg);
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge ref_clk);
    sys_rst = 1'b0;
    rd(8'hD4, 8'hFF);
    rd(8'h84, 8'hFF);
    rd(8'h8C, 8'h00);
    wr(8'h90, 8'h00, 1'b0);
    wr(8'hD3, 8'h5A, 1'b1);
    rd(8'hD3, 8'h5A);
    wr(8'h83, 8'hA5, 1'b1);
    rd(8'h83, 8'hA5);
    rx(1'b1, 1'b1, 1'b1);
    pulse(flag_clear);
    chk(plain_packet_received_flag, 1'b0);
    wr(8'hD4, 8'h7F, 1'b1);
    wr(8'hD4, 8'h5D, 1'b1);
    wr(8'hD4, 8'h5F, 1'b0);
    wr(8'hD4, 8'hDD, 1'b0);
    wr(8'hD4, 8'h7D, 1'b0);
    rd(8'hD4, 8'h5D);
    rx(1'b1, 1'b0, 1'b0);
    rx(1'b0, 1'b1, 1'b0);
    rd(8'h84, 8'hFF);
    chk({node_role, join_send_key}, 2'b10);
    wr(8'h84, 8'hEF, 1'b0);
    vol_key_clear = 1'b1;
    nv_key_clear = 1'b1;
    wr(8'h84, 8'hEF, 1'b1);
    chk({node_role, join_send_key, join_addr_change_ok}, 3'b011);
    own_address = 32'h1234_5678;
    pulse(key_generated);
    chk(assigned_address, 32'h1234_5678);
    pulse(join_assign);
    rd(8'h8C, 8'h12);
    rd(8'h8D, 8'h34);
    rd(8'h8E, 8'h56);
    rd(8'h8F, 8'h79);
    join_key_change_req = 1'b1;
    #1 chk(key_change_ok, 1'b1);
    wr(8'h84, 8'hE3, 1'b1);
    chk({key_change_ok, join_addr_change_ok}, 2'b00);
    serial_key_change_req = 1'b1;
    #1 chk(key_change_ok, 1'b1);
    serial_key_change_req = 1'b0;
    join_key_change_req = 1'b0;
    wr(8'h84, 8'hFF, 1'b1);
    chk(node_role, 1'b1);
    pulse(button_key_generate);
    chk(node_role, 1'b0);
    rd(8'hD4, 8'h4D);
    // presses kept far shorter than the short limit
    repeat (4) begin
      pairing_button_input = 1'b1;
      repeat (5) @(negedge ref_clk);
      pairing_button_input = 1'b0;
      repeat (5) @(negedge ref_clk);
    end
    pairing_button_input = 1'b1;
    for (int i = 0; i < 100 && factory_restore !== 1'b1; i++) @(negedge ref_clk);
    chk(factory_restore, 1'b1);
    pairing_button_input = 1'b0;
    @(negedge ref_clk);
    rd(8'hD4, 8'hFF);
    rd(8'h84, 8'hFF);
    rd(8'hD3, 8'h00);
    rd(8'h8C, 8'h00);
    wr(8'h8E, 8'h3C, 1'b1);
    rd(8'h8E, 8'h3C);
    rd(8'h8F, 8'h00);
    stop_test();
  end
  initial begin
    repeat (5000) @(posedge ref_clk);
    err_count++;
    stop_test();
  end
endmodule
